//--- rtl/ars_sync_top.sv
// serial slave port and sample timing of the rate sensor
//
// Behaviour
// - output bit changes on falling serial clock edge
// - input bit captured on rising serial clock edge
// - external sample clock used only when sample period field is zero
// - data ready comes no earlier than 360 us after sync edge
// - mode 3 link, 16-bit words, most significant bit first
// - read takes two frames; reply comes during the next frame
// - output line released while chip select is high
// - data ready line pulses high after every sample cycle
`timescale 1ns/1ps
module ars_sync_top
#(
  parameter int unsigned READY_CYCLES = ars_pkg::READY_CYCLES,
  parameter int unsigned LOCK_CYCLES  = ars_pkg::SYNC_LOCK_CYCLES,
  parameter int unsigned TICK_CYCLES  = ars_pkg::INT_TICK_CYCLES,
  parameter int unsigned PULSE_CYCLES = ars_pkg::READY_PULSE_CYCLES
)
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  output logic             sdo_out,
  output logic             sdo_oe_n,
  input  wire logic        external_sample_clock_in,
  input  wire logic [15:0] sample_period_field,
  output logic [6:0]       reg_addr,
  output logic             reg_rd_req,
  output logic             reg_wr_req,
  output logic [7:0]       reg_wr_data,
  input  wire logic [15:0] reg_rd_data,
  output logic             sample_start,
  output logic             data_ready_line
);

  // ----------------------------------------------------------------
  // link side
  // ----------------------------------------------------------------
  ars_frame_if frm ();

  ars_spi_link u_link
  (
    .sclk     (sclk),
    .cs_n     (cs_n),
    .sdi      (sdi),
    .sdo_out  (sdo_out),
    .sdo_oe_n (sdo_oe_n),
    .frm      (frm)
  );

  // ----------------------------------------------------------------
  // frame done crossing
  // ----------------------------------------------------------------
  logic done_s1_reg;
  logic done_s2_reg;
  logic done_s3_reg;
  logic done_lvl_reg;
  logic frame_evt;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      done_s1_reg  <= 1'b0;
      done_s2_reg  <= 1'b0;
      done_s3_reg  <= 1'b0;
      done_lvl_reg <= 1'b0;
    end
    else
    begin
      done_s1_reg <= frm.frame_done;
      done_s2_reg <= done_s1_reg;
      done_s3_reg <= done_s2_reg;
      if (done_s2_reg == done_s3_reg)
        done_lvl_reg <= done_s2_reg;
    end
  end

  assign frame_evt = done_s2_reg && done_s3_reg && !done_lvl_reg;

  // ----------------------------------------------------------------
  // request decode and reply word
  // ----------------------------------------------------------------
  logic        rd_pend_reg;
  logic [15:0] tx_word_reg;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      reg_addr    <= '0;
      reg_rd_req  <= 1'b0;
      reg_wr_req  <= 1'b0;
      reg_wr_data <= '0;
      rd_pend_reg <= 1'b0;
    end
    else
    begin
      reg_rd_req  <= frame_evt && !frm.rx_word[ars_pkg::RW_BIT];
      reg_wr_req  <= frame_evt && frm.rx_word[ars_pkg::RW_BIT];
      rd_pend_reg <= reg_rd_req;
      if (frame_evt)
      begin
        reg_addr    <= frm.rx_word[ars_pkg::ADDR_HI:ars_pkg::ADDR_LO];
        reg_wr_data <= frm.rx_word[ars_pkg::WDATA_HI:ars_pkg::WDATA_LO];
      end
    end
  end

  // word stays still until the next frame ends, well inside the stall time
  always_ff @(posedge clock)
  begin
    if (srst)
      tx_word_reg <= ars_pkg::IDLE_WORD;
    else if (rd_pend_reg)
      tx_word_reg <= reg_rd_data;
    else if (reg_wr_req)
      tx_word_reg <= ars_pkg::IDLE_WORD;
  end

  assign frm.tx_word = tx_word_reg;

  // ----------------------------------------------------------------
  // external sample clock synchroniser
  // ----------------------------------------------------------------
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic ext_s3_reg;
  logic ext_lvl_reg;
  logic ext_rise;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ext_s1_reg  <= 1'b0;
      ext_s2_reg  <= 1'b0;
      ext_s3_reg  <= 1'b0;
      ext_lvl_reg <= 1'b0;
    end
    else
    begin
      ext_s1_reg <= external_sample_clock_in;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      if (ext_s2_reg == ext_s3_reg)
        ext_lvl_reg <= ext_s2_reg;
    end
  end

  assign ext_rise = ext_s2_reg && ext_s3_reg && !ext_lvl_reg;

  // ----------------------------------------------------------------
  // sample trigger selection
  // ----------------------------------------------------------------
  logic                       ext_mode;
  logic [ars_pkg::TMR_W-1:0]  lock_cnt_reg;
  logic [ars_pkg::TMR_W-1:0]  tick_cnt_reg;
  logic [15:0]                prd_cnt_reg;
  logic                       int_evt;
  logic                       trig;

  assign ext_mode = (sample_period_field == ars_pkg::EXT_CLOCK_SEL);

  // lockout spans high pulse plus low time after an accepted edge
  always_ff @(posedge clock)
  begin
    if (srst)
      lock_cnt_reg <= '0;
    else if (ext_mode && ext_rise && lock_cnt_reg == '0)
      lock_cnt_reg <= ars_pkg::TMR_W'(LOCK_CYCLES);
    else if (lock_cnt_reg != '0)
      lock_cnt_reg <= lock_cnt_reg - 1'b1;
  end

  // internal timer: one sample every field value times a base tick
  always_ff @(posedge clock)
  begin
    if (srst || ext_mode)
    begin
      tick_cnt_reg <= '0;
      prd_cnt_reg  <= '0;
    end
    else if (tick_cnt_reg >= ars_pkg::TMR_W'(TICK_CYCLES - 1))
    begin
      tick_cnt_reg <= '0;
      if (prd_cnt_reg >= sample_period_field - 16'h0001)
        prd_cnt_reg <= '0;
      else
        prd_cnt_reg <= prd_cnt_reg + 16'h0001;
    end
    else
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
  end

  assign int_evt = !ext_mode && tick_cnt_reg >= ars_pkg::TMR_W'(TICK_CYCLES - 1) &&
                   prd_cnt_reg >= sample_period_field - 16'h0001;
  assign trig    = ext_mode ? (ext_rise && lock_cnt_reg == '0) : int_evt;

  // ----------------------------------------------------------------
  // sample cycle and data ready
  // ----------------------------------------------------------------
  ars_pkg::ars_state_t        state_reg;
  logic [ars_pkg::TMR_W-1:0]  proc_cnt_reg;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_reg       <= ars_pkg::ARS_IDLE;
      proc_cnt_reg    <= '0;
      sample_start    <= 1'b0;
      data_ready_line <= 1'b0;
    end
    else
    begin
      sample_start <= 1'b0;
      case (state_reg)
        ars_pkg::ARS_IDLE:
        begin
          data_ready_line <= 1'b0;
          if (trig)
          begin
            sample_start <= 1'b1;
            proc_cnt_reg <= ars_pkg::TMR_W'(READY_CYCLES - 1);
            state_reg    <= ars_pkg::ARS_PROC;
          end
        end
        ars_pkg::ARS_PROC:
        begin
          if (proc_cnt_reg == '0)
          begin
            data_ready_line <= 1'b1;
            proc_cnt_reg    <= ars_pkg::TMR_W'(PULSE_CYCLES - 1);
            state_reg       <= ars_pkg::ARS_FLAG;
          end
          else
            proc_cnt_reg <= proc_cnt_reg - 1'b1;
        end
        ars_pkg::ARS_FLAG:
        begin
          if (proc_cnt_reg == '0)
          begin
            data_ready_line <= 1'b0;
            state_reg       <= ars_pkg::ARS_IDLE;
          end
          else
            proc_cnt_reg <= proc_cnt_reg - 1'b1;
        end
        default:
        begin
          data_ready_line <= 1'b0;
          state_reg       <= ars_pkg::ARS_IDLE;
        end
      endcase
    end
  end

endmodule

//--- rtl/ars_pkg.sv
// constants shared by the serial port and the sample timing logic
package ars_pkg;

  // ----------------------------------------------------------------
  // serial frame layout
  // ----------------------------------------------------------------
  localparam int unsigned FRAME_BITS    = 16;
  localparam int unsigned CNT_W         = 5;
  localparam logic [4:0]  CNT_LAST      = 5'h0F;
  localparam logic [4:0]  CNT_FULL      = 5'h10;
  localparam int unsigned RW_BIT        = 15;
  localparam int unsigned ADDR_HI       = 14;
  localparam int unsigned ADDR_LO       = 8;
  localparam int unsigned ADDR_W        = 7;
  localparam int unsigned WDATA_HI      = 7;
  localparam int unsigned WDATA_LO      = 0;
  localparam logic [15:0] IDLE_WORD     = 16'h0000;

  // ----------------------------------------------------------------
  // sample timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 20;
  localparam int unsigned NS_PER_US         = 1000;
  localparam int unsigned SYNC_HIGH_MIN_US  = 5;
  localparam int unsigned SYNC_LOW_MIN_US   = 100;
  localparam int unsigned SYNC_TO_READY_US  = 360;
  localparam int unsigned SYNC_LOCK_CYCLES  =
    ((SYNC_HIGH_MIN_US + SYNC_LOW_MIN_US) * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READY_CYCLES      =
    (SYNC_TO_READY_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READY_PULSE_CYCLES = 16;
  localparam int unsigned INT_TICK_CYCLES    = 1000;
  localparam logic [15:0] EXT_CLOCK_SEL      = 16'h0000;
  localparam int unsigned TMR_W              = 32;

  // ----------------------------------------------------------------
  // sample cycle states
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ARS_IDLE = 2'h0,
    ARS_PROC = 2'h1,
    ARS_FLAG = 2'h3
  } ars_state_t;

endpackage

//--- rtl/ars_frame_if.sv
// frame words passed between the serial link logic and the core
`timescale 1ns/1ps
interface ars_frame_if;
  logic        frame_done;
  logic [15:0] rx_word;
  logic [15:0] tx_word;

  modport link
  (
    output frame_done,
    output rx_word,
    input  tx_word
  );

  modport core
  (
    input  frame_done,
    input  rx_word,
    output tx_word
  );
endinterface

//--- rtl/ars_spi_link.sv
// serial shift logic running on the link clock
`timescale 1ns/1ps
module ars_spi_link
(
  input  wire logic  sclk,
  input  wire logic  cs_n,
  input  wire logic  sdi,
  output logic       sdo_out,
  output logic       sdo_oe_n,
  ars_frame_if.link  frm
);

  // ----------------------------------------------------------------
  // receive side
  // ----------------------------------------------------------------
  logic [ars_pkg::CNT_W-1:0]      in_cnt_reg;
  logic [ars_pkg::FRAME_BITS-1:0] in_shift_reg;
  logic [ars_pkg::FRAME_BITS-1:0] rx_hold_reg;
  logic                           done_reg;
  logic [ars_pkg::CNT_W-1:0]      out_cnt_reg;

  // counter cleared by the frame's own select
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      in_cnt_reg <= '0;
      done_reg   <= 1'b0;
    end
    else if (in_cnt_reg != ars_pkg::CNT_FULL)
    begin
      in_cnt_reg <= in_cnt_reg + 5'h01;
      if (in_cnt_reg == ars_pkg::CNT_LAST)
        done_reg <= 1'b1;
    end
  end

  // capture on rising edge, msb first
  always_ff @(posedge sclk)
  begin
    if (!cs_n && in_cnt_reg != ars_pkg::CNT_FULL)
      in_shift_reg <= {in_shift_reg[ars_pkg::FRAME_BITS-2:0], sdi};
    if (!cs_n && in_cnt_reg == ars_pkg::CNT_LAST)
      rx_hold_reg <= {in_shift_reg[ars_pkg::FRAME_BITS-2:0], sdi};
  end

  // ----------------------------------------------------------------
  // transmit side
  // ----------------------------------------------------------------
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      out_cnt_reg <= '0;
      sdo_out     <= 1'b0;
      sdo_oe_n    <= 1'b1;
    end
    else
    begin
      sdo_oe_n <= 1'b0;
      if (out_cnt_reg != ars_pkg::CNT_FULL)
      begin
        sdo_out     <= frm.tx_word[ars_pkg::CNT_LAST[3:0] - out_cnt_reg[3:0]];
        out_cnt_reg <= out_cnt_reg + 5'h01;
      end
    end
  end

  assign frm.frame_done = done_reg;
  assign frm.rx_word    = rx_hold_reg;

endmodule

//--- test/ars_sva.sv
// assertions on the rate sensor port pins
`timescale 1ns/1ps
module ars_sva
#(
  parameter int unsigned READY_CYCLES = 20
)
(
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        sclk,
  input wire logic        cs_n,
  input wire logic        sdo_out,
  input wire logic        sdo_oe_n,
  input wire logic        external_sample_clock_in,
  input wire logic [15:0] sample_period_field,
  input wire logic        reg_rd_req,
  input wire logic        reg_wr_req,
  input wire logic        sample_start,
  input wire logic        data_ready_line
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_pulse;
    data_ready_line [*2] ##1 !data_ready_line;
  endsequence
  sequence s_ready;
    $rose(data_ready_line) ##0 s_pulse;
  endsequence
  property p_release;
    cs_n && $past(cs_n) |-> sdo_oe_n;
  endproperty
  property p_out_edge;
    !cs_n && !$past(cs_n) && $changed(sdo_out) |-> !sclk;
  endproperty
  property p_oe_edge;
    $fell(sdo_oe_n) |-> !cs_n && !sclk;
  endproperty
  property p_ready_lat;
    sample_start |-> ##READY_CYCLES s_ready;
  endproperty
  property p_ready_early;
    $rose(data_ready_line) |-> $past(sample_start, READY_CYCLES);
  endproperty
  property p_width;
    $rose(data_ready_line) |-> s_pulse;
  endproperty
  property p_one_start;
    sample_start |=> !sample_start [*8];
  endproperty
  property p_ext_sel;
    sample_start && sample_period_field == 16'h0000 |->
      external_sample_clock_in && !$past(external_sample_clock_in, 6);
  endproperty
  property p_req_pulse;
    reg_rd_req || reg_wr_req |=> !reg_rd_req && !reg_wr_req;
  endproperty
  a_release: assert property (p_release)
    else $error("output driven while deselected");
  a_out_edge: assert property (p_out_edge)
    else $error("output bit changed while serial clock high");
  a_oe_edge: assert property (p_oe_edge)
    else $error("output enabled outside a falling clock edge");
  a_ready_lat: assert property (p_ready_lat)
    else $error("data ready not at the processing latency");
  a_ready_early: assert property (p_ready_early)
    else $error("data ready without a sample start");
  a_width: assert property (p_width)
    else $error("data ready pulse width wrong");
  a_one_start: assert property (p_one_start)
    else $error("sample starts too close together");
  a_ext_sel: assert property (p_ext_sel)
    else $error("external sample start without sync edge");
  a_req_pulse: assert property (p_req_pulse)
    else $error("request longer than one cycle");
endmodule

//--- test/ars_host.sv
// host side serial master model
`timescale 1ns/1ps
module ars_host
(
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  realtime t_start = 0;
  realtime t_end   = 0;
  // idle levels set just after time zero so the link's asynchronous clear sees a real edge
  initial
  begin
    #1;
    cs_n = 1'b1;
    sclk = 1'b1;
    sdi  = 1'b0;
  end
  // one frame of nbits clocks, mode 3, msb first
  task automatic xfer(input logic [15:0] w, input int nbits, input int slow,
                      output logic [15:0] r);
    r = 16'h0000;
    while ($realtime < t_start + 25000 + slow || $realtime < t_end + 9000) #1;
    t_start = $realtime;
    cs_n = 1'b0;
    #49;
    for (int i = 15; i > 15 - nbits; i--)
    begin
      sclk = 1'b0;
      sdi  = w[i];
      #24;
      sclk = 1'b1;
      r[i] = sdo;
      #24;
    end
    #100;
    cs_n = 1'b1;
    sdi  = ~sdi;
    t_end = $realtime;
  endtask
endmodule

//--- test/ars_sync_tb.sv
// self-checking bench for the serial port and sample timing
`timescale 1ns/1ps
module ars_sync_tb;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        ext_in = 1'b0;
  logic [15:0] field = 16'h0000;
  logic [15:0] rd_data = 16'h0000;
  wire         sclk, cs_n, sdi, sdo;
  logic        sdo_out, sdo_oe_n, rd_req, wr_req, start, ready, ready_q;
  logic [6:0]  addr;
  logic [7:0]  wdata;
  logic [31:0] seed = 32'hcb7a;
  logic [15:0] exp_reply = 16'h0000;
  logic [15:0] got, w, req_word;
  int          n_fail = 0, total_checks = 0, cyc = 0;
  int          n_start = 0, n_ready = 0, n_req = 0, gap = 0, last = 0, n0;

  ars_sync_top #(.READY_CYCLES(20), .LOCK_CYCLES(30), .TICK_CYCLES(10), .PULSE_CYCLES(2)) dut
  (.clock(clock), .srst(srst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_out(sdo_out),
   .sdo_oe_n(sdo_oe_n), .external_sample_clock_in(ext_in), .sample_period_field(field),
   .reg_addr(addr), .reg_rd_req(rd_req), .reg_wr_req(wr_req), .reg_wr_data(wdata),
   .reg_rd_data(rd_data), .sample_start(start), .data_ready_line(ready));
  ars_host host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

  assign sdo = sdo_oe_n ? 1'bz : sdo_out;
  always #10 clock = ~clock;
  always @(posedge clock) rd_data <= {~addr, 1'b1, addr, 1'b0};

  // ----
  // monitor and timeout
  // ----
  always @(posedge clock)
  begin
    cyc++;
    if (start)
    begin
      n_start++;
      gap = cyc - last;
      last = cyc;
    end
    if (ready && !ready_q) n_ready++;
    ready_q = ready;
    if (rd_req || wr_req)
    begin
      n_req++;
      req_word = {wr_req, addr, wdata};
    end
    if (cyc > 20000)
    begin
      n_fail++;
      test_done();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk_word(input string name, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", name, e, g);
    end
  endtask
  task automatic chk_cnt(input string name, input int e, input int g);
    total_checks++;
    if (g != e)
    begin
      n_fail++;
      $display("BAD %s exp %0d got %0d", name, e, g);
    end
  endtask
  task automatic frame(input int nbits);
    n0 = n_req;
    host.xfer(w, nbits, int'(rnd() & 32'h3FF), got);
    repeat (10) @(posedge clock);
    if (nbits < 16)
      chk_cnt("requests", n0, n_req);
    else
    begin
      chk_word("reply", exp_reply, got);
      chk_word("request", w, req_word);
      exp_reply = w[15] ? 16'h0000 : {~w[14:8], 1'b1, w[14:8], 1'b0};
    end
  endtask
  task automatic sync_pulse(input int n);
    ext_in <= 1'b1;
    repeat (n) @(posedge clock);
    ext_in <= 1'b0;
  endtask
  task automatic test_done();
    if (n_fail == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----
  // main sequence
  // ----
  initial
  begin
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    for (int k = 0; k < 10; k++)
    begin
      w = 16'(rnd());
      w[15] = (k % 3 == 2);
      frame(k == 4 ? 9 : 16);
    end
    for (int k = 0; k < 3; k++)
    begin
      sync_pulse(10);
      repeat (15) @(posedge clock);
      sync_pulse(5);
      repeat (60) @(posedge clock);
    end
    chk_cnt("sync starts", 3, n_start);
    field <= 16'h0003;
    repeat (100) @(posedge clock);
    sync_pulse(10);
    repeat (4)
    begin
      @(posedge clock iff start);
      @(negedge clock);
      chk_cnt("tick gap", 30, gap);
    end
    @(posedge clock);
    field <= 16'h0000;
    repeat (40) @(posedge clock);
    chk_cnt("ready pulses", n_start, n_ready);
    test_done();
  end
endmodule

bind ars_sync_top ars_sva #(.READY_CYCLES(READY_CYCLES)) chk
(.clock(clock), .srst(srst), .sclk(sclk), .cs_n(cs_n), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
 .external_sample_clock_in(external_sample_clock_in), .sample_period_field(sample_period_field),
 .reg_rd_req(reg_rd_req), .reg_wr_req(reg_wr_req), .sample_start(sample_start),
 .data_ready_line(data_ready_line));
